// file: tenbase_t_pcs_pkg.sv
package tenbase_t_pcs_pkg;

  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFFSET          = 8'h00;
  localparam logic [7:0] STATUS_OFFSET        = 8'h04;

  // control fields
  localparam int         CTRL_SPEED_100_BIT   = 0;
  localparam int         CTRL_SERIAL_BIT      = 1;
  localparam int         CTRL_JABBER_DIS_BIT  = 12;
  localparam logic       CTRL_SPEED_100_RST   = 1'b0;
  localparam logic       CTRL_SERIAL_RST      = 1'b0;
  localparam logic       CTRL_JABBER_DIS_RST  = 1'b0;

  // status fields
  localparam int         STAT_LINK_PASS_BIT   = 0;
  localparam int         STAT_JABBER_BIT      = 1;
  localparam int         STAT_POL_INV_BIT     = 2;
  localparam int         STAT_POL_LOCK_BIT    = 3;
  localparam int         STAT_RX_LOCK_BIT     = 4;
  localparam int         STAT_SYNTH_100_BIT   = 5;
  localparam int         STAT_CODE_VIOL_BIT   = 6;

  localparam logic [1:0] RESP_OKAY            = 2'b00;
  localparam logic [1:0] RESP_SLVERR          = 2'b10;

  // timing
  localparam int         CLK_NS               = 10;
  localparam int         TX_CLK_NS            = 40;
  localparam int         BIT10_NS             = 100;
  localparam int         TX_CLK_DIV           = TX_CLK_NS / CLK_NS;
  localparam int         BIT_CYCLES           = BIT10_NS / CLK_NS;
  localparam int         HALF_CYCLES          = BIT_CYCLES / 2;
  localparam int         JABBER_MS            = 100;
  localparam int         UNJAB_MS             = 500;
  localparam int         JABBER_BITS_DEF      = JABBER_MS * 1000000 / BIT10_NS;
  localparam int         UNJAB_BITS_DEF       = UNJAB_MS * 1000000 / BIT10_NS;
  localparam int         NLP_INTERVAL_MS      = 16;
  localparam int         NLP_INTERVAL_DEF     = NLP_INTERVAL_MS * 1000000 / CLK_NS;
  localparam int         NLP_WIDTH_NS         = 100;
  localparam int         NLP_WIDTH_CYCLES     = NLP_WIDTH_NS / CLK_NS;
  localparam int         RUN_MAX_BITS         = 60;
  localparam int         SYMBOL_BITS          = 5;
  localparam int         NIBBLE_BITS          = 4;
  localparam int         LOCK_PACKETS         = 2;

  typedef enum logic {LINK_FAIL, LINK_PASS} link_state_t;

endpackage : tenbase_t_pcs_pkg

// file: tenbase_t_pcs_link_control.sv
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
module tenbase_t_pcs_link_control
  import tenbase_t_pcs_pkg::*;
#(
  parameter int unsigned JABBER_LIMIT_BITS = JABBER_BITS_DEF,
  parameter int unsigned UNJAB_BITS        = UNJAB_BITS_DEF,
  parameter int unsigned NLP_INTERVAL      = NLP_INTERVAL_DEF
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // line side (asynchronous)
  input  wire logic        line_bit_clk,
  input  wire logic        line_bit,
  input  wire logic        signal_detect,
  input  wire logic        rx_activity,
  input  wire logic        link_pulse_in,
  input  wire logic        link_pulse_neg,
  output logic             line_tx,
  output logic             line_tx_en,
  // auto-negotiation
  input  wire logic        aneg_link_good,
  // mac side
  input  wire logic [3:0]  mac_txd,
  input  wire logic        mac_tx_en,
  output logic             mac_tx_take,
  output logic             mac_rx_clk,
  output logic [4:0]       rx_symbol,
  output logic             rx_symbol_valid,
  output logic [3:0]       rx_nibble,
  output logic             rx_nibble_valid,
  output logic             crs,
  output logic             col,
  // clocking status
  output logic             synth_100_set
);

  typedef struct packed {
    logic [2:0]  bclk_sync;
    logic [1:0]  bit_sync;
    logic [1:0]  sd_sync;
    logic [1:0]  act_sync;
    logic [2:0]  nlp_sync;
    logic [1:0]  neg_sync;
    logic        prev_line;
    logic [4:0]  shift5;
    logic [2:0]  cnt5;
    logic [4:0]  symbol;
    logic        symbol_valid;
    logic [5:0]  run_cnt;
    logic        rx_locked;
    logic        rx_clk;
    logic [1:0]  tx_div;
    logic        half_phase;
    logic        first_half;
    logic [3:0]  shift4;
    logic [1:0]  cnt4;
    logic [3:0]  nibble;
    logic        nibble_valid;
    logic        code_viol;
    logic        synth_100;
    link_state_t link;
    logic        pol_inv;
    logic        pol_known;
    logic        pol_locked;
    logic [1:0]  pkt_cnt;
    logic        act_prev;
    logic [3:0]  bit_cnt;
    logic [1:0]  tx_idx;
    logic [3:0]  tx_shift;
    logic        tx_running;
    logic        tx_out;
    logic        tx_out_en;
    logic        tx_take;
    logic [22:0] jab_cnt;
    logic        jabbering;
    logic        jabber_stat;
    logic [22:0] unjab_cnt;
    logic [20:0] nlp_cnt;
    logic [3:0]  nlp_width;
    logic        crs;
    logic        col;
    logic        speed_100;
    logic        serial_mode;
    logic        jabber_dis;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic        bclk_rise;
  logic        nlp_rise;
  logic        rx_b;
  logic        bit_tick;
  logic        manch;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;

  assign bclk_rise = state_reg.bclk_sync[1] & ~state_reg.bclk_sync[2];
  assign nlp_rise  = state_reg.nlp_sync[1] & ~state_reg.nlp_sync[2];
  assign rx_b      = state_reg.bit_sync[1] ^ state_reg.pol_inv;
  assign bit_tick  = (state_reg.bit_cnt == 4'(BIT_CYCLES - 1));
  assign manch     = (state_reg.bit_cnt < 4'(HALF_CYCLES)) ? ~state_reg.tx_shift[0] : state_reg.tx_shift[0];

  always_comb begin
    status_word = 32'h0;
    status_word[STAT_LINK_PASS_BIT] = (state_reg.link == LINK_PASS);
    status_word[STAT_JABBER_BIT]    = state_reg.jabber_stat;
    status_word[STAT_POL_INV_BIT]   = state_reg.pol_inv;
    status_word[STAT_POL_LOCK_BIT]  = state_reg.pol_locked;
    status_word[STAT_RX_LOCK_BIT]   = state_reg.rx_locked;
    status_word[STAT_SYNTH_100_BIT] = state_reg.synth_100;
    status_word[STAT_CODE_VIOL_BIT] = state_reg.code_viol;
    ctrl_word = 32'h0;
    ctrl_word[CTRL_SPEED_100_BIT]  = state_reg.speed_100;
    ctrl_word[CTRL_SERIAL_BIT]     = state_reg.serial_mode;
    ctrl_word[CTRL_JABBER_DIS_BIT] = state_reg.jabber_dis;
  end

  always_comb begin
    state_next = state_reg;
    state_next.symbol_valid = 1'b0;
    state_next.nibble_valid = 1'b0;
    state_next.tx_take      = 1'b0;

    // two-flop synchronisers, third stage only for edge finding
    state_next.bclk_sync = {state_reg.bclk_sync[1:0], line_bit_clk};
    state_next.bit_sync  = {state_reg.bit_sync[0], line_bit};
    state_next.sd_sync   = {state_reg.sd_sync[0], signal_detect};
    state_next.act_sync  = {state_reg.act_sync[0], rx_activity};
    state_next.nlp_sync  = {state_reg.nlp_sync[1:0], link_pulse_in};
    state_next.neg_sync  = {state_reg.neg_sync[0], link_pulse_neg};

    // axi4-lite: status read clears sticky bits; hardware set below wins
    if (s_axi_awvalid && !state_reg.aw_held && !state_reg.bvalid) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_held && !state_reg.bvalid) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = RESP_OKAY;
      if (state_reg.aw_addr[7:2] == CTRL_OFFSET[7:2]) begin
        if (state_reg.w_strb[0]) begin
          state_next.speed_100   = state_reg.w_data[CTRL_SPEED_100_BIT];
          state_next.serial_mode = state_reg.w_data[CTRL_SERIAL_BIT];
        end
        if (state_reg.w_strb[1]) begin
          state_next.jabber_dis = state_reg.w_data[CTRL_JABBER_DIS_BIT];
        end
      end else if (state_reg.aw_addr[7:2] != STATUS_OFFSET[7:2]) begin
        state_next.bresp = RESP_SLVERR;
      end
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !state_reg.rvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = RESP_OKAY;
      if (s_axi_araddr[7:2] == CTRL_OFFSET[7:2]) begin
        state_next.rdata = ctrl_word;
      end else if (s_axi_araddr[7:2] == STATUS_OFFSET[7:2]) begin
        state_next.rdata       = status_word;
        state_next.jabber_stat = 1'b0;
        state_next.code_viol   = 1'b0;
      end else begin
        state_next.rdata = 32'h0;
        state_next.rresp = RESP_SLVERR;
      end
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end

    // clock synthesizer set follows speed selection
    state_next.synth_100 = state_reg.speed_100;

    // transmit-side 25 MHz from the reference
    state_next.tx_div = 2'(state_reg.tx_div + 2'h1);

    // recovered-clock receive path
    if (!state_reg.sd_sync[1]) begin
      state_next.rx_locked = 1'b0;
      state_next.run_cnt   = 6'h0;
    end
    if (bclk_rise && state_reg.speed_100 && state_reg.sd_sync[1]) begin
      state_next.prev_line = state_reg.bit_sync[1];
      state_next.shift5    = {state_reg.bit_sync[1] ^ state_reg.prev_line, state_reg.shift5[4:1]};
      if (state_reg.cnt5 == 3'(SYMBOL_BITS - 1)) begin
        state_next.cnt5         = 3'h0;
        state_next.symbol       = {state_reg.bit_sync[1] ^ state_reg.prev_line, state_reg.shift5[4:1]};
        state_next.symbol_valid = state_reg.rx_locked;
      end else begin
        state_next.cnt5 = 3'(state_reg.cnt5 + 3'h1);
      end
      if (state_reg.bit_sync[1] != state_reg.prev_line) begin
        state_next.run_cnt   = 6'h0;
        state_next.rx_locked = 1'b1;
      end else if (state_reg.run_cnt >= 6'(RUN_MAX_BITS)) begin
        state_next.rx_locked = 1'b0;
      end else begin
        state_next.run_cnt = 6'(state_reg.run_cnt + 6'h1);
      end
    end
    // receive clock: line-derived divide by five, else transmit clock
    if (state_reg.rx_locked && state_reg.speed_100) begin
      state_next.rx_clk = (state_next.cnt5 < 3'h2);
    end else begin
      state_next.rx_clk = (state_reg.tx_div < 2'(TX_CLK_DIV / 2));
    end

    // 10M Manchester receive: line clock edges carry half-bit samples
    if (!state_reg.act_sync[1] || state_reg.speed_100) begin
      state_next.half_phase = 1'b0;
      state_next.cnt4       = 2'h0;
    end else if (bclk_rise) begin
      state_next.half_phase = ~state_reg.half_phase;
      if (!state_reg.half_phase) begin
        state_next.first_half = rx_b;
      end else begin
        if (state_reg.first_half == rx_b) begin
          state_next.code_viol = 1'b1;
        end
        state_next.shift4 = {rx_b, state_reg.shift4[3:1]};
        state_next.cnt4   = 2'(state_reg.cnt4 + 2'h1);
        if (state_reg.cnt4 == 2'(NIBBLE_BITS - 1)) begin
          state_next.nibble       = {rx_b, state_reg.shift4[3:1]};
          state_next.nibble_valid = 1'b1;
        end
      end
    end

    // link state
    case (state_reg.link)
      LINK_FAIL: if (aneg_link_good) state_next.link = LINK_PASS;
      LINK_PASS: if (!aneg_link_good) state_next.link = LINK_FAIL;
      default:   state_next.link = LINK_FAIL;
    endcase

    // polarity from first link pulse, locked by packets
    state_next.act_prev = state_reg.act_sync[1];
    if (nlp_rise && !state_reg.pol_known && !state_reg.pol_locked) begin
      state_next.pol_inv   = state_reg.neg_sync[1];
      state_next.pol_known = 1'b1;
    end
    if (state_reg.act_prev && !state_reg.act_sync[1] && state_reg.pol_known && !state_reg.pol_locked) begin
      state_next.pkt_cnt = 2'(state_reg.pkt_cnt + 2'h1);
      if (state_reg.pkt_cnt == 2'(LOCK_PACKETS - 1)) begin
        state_next.pol_locked = 1'b1;
      end
    end
    if (state_reg.link == LINK_FAIL && !aneg_link_good) begin
      state_next.pol_locked = 1'b0;
      state_next.pol_known  = 1'b0;
      state_next.pkt_cnt    = 2'h0;
    end

    // 10M transmit: nibble or serial, one bit each bit time
    state_next.bit_cnt = bit_tick ? 4'h0 : 4'(state_reg.bit_cnt + 4'h1);
    if (bit_tick) begin
      if (state_reg.speed_100) begin
        state_next.tx_running = 1'b0;
        state_next.tx_idx     = 2'h0;
      end else if (state_reg.serial_mode) begin
        state_next.tx_shift   = {3'h0, mac_txd[0]};
        state_next.tx_running = mac_tx_en;
        state_next.tx_take    = mac_tx_en;
      end else if (state_reg.tx_idx == 2'h0) begin
        state_next.tx_shift   = mac_txd;
        state_next.tx_running = mac_tx_en;
        state_next.tx_take    = mac_tx_en;
        state_next.tx_idx     = mac_tx_en ? 2'h1 : 2'h0;
      end else begin
        state_next.tx_shift = {1'b0, state_reg.tx_shift[3:1]};
        state_next.tx_idx   = 2'(state_reg.tx_idx + 2'h1);
      end
    end

    // jabber and unjab timers in bit times
    if (state_reg.jabber_dis) begin
      state_next.jabbering = 1'b0;
      state_next.jab_cnt   = 23'h0;
    end else if (bit_tick) begin
      if (!state_reg.jabbering) begin
        if (!state_reg.tx_running) begin
          state_next.jab_cnt = 23'h0;
        end else if (state_reg.jab_cnt >= 23'(JABBER_LIMIT_BITS - 1)) begin
          state_next.jabbering   = 1'b1;
          state_next.jabber_stat = 1'b1;
          state_next.unjab_cnt   = 23'h0;
        end else begin
          state_next.jab_cnt = 23'(state_reg.jab_cnt + 23'h1);
        end
      end else if (state_reg.tx_running) begin
        state_next.unjab_cnt = 23'h0;
      end else if (state_reg.unjab_cnt >= 23'(UNJAB_BITS - 1)) begin
        state_next.jabbering = 1'b0;
        state_next.jab_cnt   = 23'h0;
      end else begin
        state_next.unjab_cnt = 23'(state_reg.unjab_cnt + 23'h1);
      end
    end
    if (state_reg.jabbering && !state_reg.jabber_dis) begin
      state_next.jabber_stat = 1'b1;
    end

    // link test pulses keep going even while jabbering
    if (state_reg.nlp_cnt >= 21'(NLP_INTERVAL - 1)) begin
      state_next.nlp_cnt   = 21'h0;
      state_next.nlp_width = 4'(NLP_WIDTH_CYCLES);
    end else begin
      state_next.nlp_cnt = 21'(state_reg.nlp_cnt + 21'h1);
      if (state_reg.nlp_width != 4'h0) begin
        state_next.nlp_width = 4'(state_reg.nlp_width - 4'h1);
      end
    end
    if (state_reg.tx_running && !state_reg.jabbering) begin
      state_next.tx_out    = manch;
      state_next.tx_out_en = 1'b1;
    end else begin
      state_next.tx_out    = 1'b1;
      state_next.tx_out_en = (state_reg.nlp_width != 4'h0) && !state_reg.speed_100;
    end

    // carrier sense and collision toward the mac
    if (state_reg.link == LINK_PASS) begin
      state_next.crs = state_reg.act_sync[1];
      state_next.col = (state_reg.tx_running && state_reg.act_sync[1]) || state_reg.jabbering;
    end else begin
      state_next.crs = 1'b0;
      state_next.col = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg             <= '0;
      state_reg.link        <= LINK_FAIL;
      state_reg.speed_100   <= CTRL_SPEED_100_RST;
      state_reg.serial_mode <= CTRL_SERIAL_RST;
      state_reg.jabber_dis  <= CTRL_JABBER_DIS_RST;
      state_reg.tx_out      <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready   = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready    = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_bvalid    = state_reg.bvalid;
  assign s_axi_bresp     = state_reg.bresp;
  assign s_axi_arready   = !state_reg.rvalid;
  assign s_axi_rvalid    = state_reg.rvalid;
  assign s_axi_rdata     = state_reg.rdata;
  assign s_axi_rresp     = state_reg.rresp;
  assign line_tx         = state_reg.tx_out;
  assign line_tx_en      = state_reg.tx_out_en;
  assign mac_tx_take     = state_reg.tx_take;
  assign mac_rx_clk      = state_reg.rx_clk;
  assign rx_symbol       = state_reg.symbol;
  assign rx_symbol_valid = state_reg.symbol_valid;
  assign rx_nibble       = state_reg.nibble;
  assign rx_nibble_valid = state_reg.nibble_valid;
  assign crs             = state_reg.crs;
  assign col             = state_reg.col;
  assign synth_100_set   = state_reg.synth_100;

endmodule : tenbase_t_pcs_link_control

// file: tenbase_t_pcs_link_control_chk.sv
`timescale 1ns/10ps
module tenbase_t_pcs_link_control_chk
  import tenbase_t_pcs_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // register bus
  input wire logic [7:0] s_axi_araddr,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  // link and mac side
  input wire logic       aneg_link_good,
  input wire logic       rx_activity,
  input wire logic       mac_tx_take,
  input wire logic       rx_symbol_valid,
  input wire logic       rx_nibble_valid,
  input wire logic       crs,
  input wire logic       col,
  input wire logic       synth_100_set,
  input wire logic       line_tx
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // link state is registered, so give it a few cycles to settle
  sequence link_up_s;
    aneg_link_good [*4];
  endsequence

  sequence rx_start_s;
    $rose(rx_activity);
  endsequence

  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  unmapped_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > STATUS_OFFSET[7:2]
    |=> s_axi_rresp == RESP_SLVERR) else $error("unmapped read not refused");
  reset_state_a: assert property ($rose(resetn) |-> !synth_100_set && line_tx)
    else $error("wrong state after reset");
  fail_quiet_a: assert property (!aneg_link_good [*3] |-> !crs && !col)
    else $error("carrier or collision in link fail");
  carrier_on_a: assert property (link_up_s ##0 rx_start_s |-> ##[1:8] crs)
    else $error("carrier sense missing");
  take_pulse_a: assert property (mac_tx_take |=> !mac_tx_take [*8])
    else $error("transmit take too close");
  sym_pulse_a: assert property (rx_symbol_valid |=> !rx_symbol_valid)
    else $error("symbol strobe too long");
  nib_pulse_a: assert property (rx_nibble_valid |=> !rx_nibble_valid)
    else $error("nibble strobe too long");
endmodule : tenbase_t_pcs_link_control_chk

bind tenbase_t_pcs_link_control tenbase_t_pcs_link_control_chk tenbase_t_pcs_link_control_chk_i (.*);

// file: line_partner.sv
`timescale 1ns/10ps
module line_partner (
  // bench control
  input  wire logic run,
  input  wire logic nrz,
  input  wire logic pulse_req,
  input  wire logic reversed,
  // line side
  output logic      line_bit_clk,
  output logic      line_bit,
  output logic      link_pulse_in,
  output logic      link_pulse_neg
);
  initial begin
    line_bit_clk = 1'b0;
    line_bit = 1'b0;
    link_pulse_in = 1'b0;
    link_pulse_neg = 1'b0;
  end

  // clock stands still between frames; idle data keeps toggling so no stale level
  always begin
    if (run) begin
      line_bit = nrz ? ~line_bit : line_bit;
      #80 line_bit_clk = 1'b1;
      #80 line_bit_clk = 1'b0;
    end else begin
      #80 line_bit = ~line_bit;
    end
  end

  always @(posedge pulse_req) begin
    link_pulse_neg = reversed;
    link_pulse_in = 1'b1;
    #100 link_pulse_in = 1'b0;
    link_pulse_neg = 1'b0;
  end
endmodule : line_partner

// file: tenbase_t_pcs_link_control_bench.sv
`timescale 1ns/10ps
module tenbase_t_pcs_link_control_bench
  import tenbase_t_pcs_pkg::*;
;
  logic        clock = 1'b0, resetn = 1'b0, clk_en = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, signal_detect = 1'b0;
  logic        rx_activity = 1'b0, aneg_link_good = 1'b0, mac_tx_en = 1'b0, sym_on = 1'b0;
  logic        run = 1'b0, nrz = 1'b1, pulse_req = 1'b0, reversed = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb = 4'hf, mac_txd = 4'h0, rx_nibble;
  logic [4:0]  sym_exp = 5'h00, rx_symbol;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, line_bit_clk;
  logic        line_bit, link_pulse_in, link_pulse_neg, line_tx, line_tx_en, mac_tx_take, mac_rx_clk;
  logic        rx_symbol_valid, rx_nibble_valid, crs, col, synth_100_set;
  int          n_fail = 0, check_count = 0, nib_seen = 0, n, cnt;

  tenbase_t_pcs_link_control #(.JABBER_LIMIT_BITS(20), .UNJAB_BITS(50), .NLP_INTERVAL(200))
    tenbase_t_pcs_link_control_i (.*);
  line_partner line_partner_i (.*);

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic check(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error %0t %s", $time, m);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    rd_resp = s_axi_bresp;
    check(n < 50, "write timeout");
    if (n >= 50) conclude();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    check(n < 50, "read timeout");
    if (n >= 50) conclude();
  endtask : rd

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick

  task automatic wait_col(input logic v, input int lim);
    n = 0;
    while (col !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
    check(col === v, "collision level");
    if (col !== v) conclude();
  endtask : wait_col

  // one serial bit: first half is the complement, second half the bit
  task automatic tx_bit(input logic b);
    mac_txd <= {3'h0, b};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (mac_tx_take !== 1'b1 && n < 50);
    check(n < 50, "take timeout");
    if (n >= 50) conclude();
    tick(3);
    check(line_tx === ~b && line_tx_en === 1'b1, "first half");
    tick(5);
    check(line_tx === b, "second half");
  endtask : tx_bit

  task automatic count_toggles(input int k);
    logic last;
    last = mac_rx_clk;
    cnt = 0;
    repeat (k) begin
      @(posedge clock);
      if (mac_rx_clk !== last)
        cnt++;
      last = mac_rx_clk;
    end
  endtask : count_toggles

  always @(posedge clock) begin
    // alternating half-bits decode to all-equal bits, whatever the phase
    if (rx_nibble_valid === 1'b1) begin
      nib_seen++;
      check(rx_nibble === 4'h0 || rx_nibble === 4'hf, "nibble value");
    end
    if (sym_on && rx_symbol_valid === 1'b1)
      check(rx_symbol === sym_exp, "symbol value");
  end

  initial begin
    #300000;
    check(1'b0, "watchdog");
    conclude();
  end

  initial begin
    tick(8);
    resetn <= 1'b1;
    tick(1);
    rd(CTRL_OFFSET);
    check(rd_data === 32'h0 && rd_resp === RESP_OKAY, "ctrl reset");
    rd(STATUS_OFFSET);
    check(rd_data[STAT_LINK_PASS_BIT] === 1'b0 && synth_100_set === 1'b0, "status reset");
    wr(STATUS_OFFSET, 32'hffff_ffff);
    check(rd_resp === RESP_OKAY, "status write");
    rd(8'h08);
    check(rd_resp === RESP_SLVERR && rd_data === 32'h0, "unmapped read");
    $display("registers done");
    aneg_link_good <= 1'b1;
    wr(CTRL_OFFSET, 32'h2);
    mac_tx_en <= 1'b1;
    rx_activity <= 1'b1;
    tx_bit(1'b1);
    tx_bit(1'b0);
    check(col === 1'b1 && crs === 1'b1, "collision");
    mac_tx_en <= 1'b0;
    rx_activity <= 1'b0;
    tick(30);
    check(col === 1'b0 && crs === 1'b0, "collision end");
    $display("transmit done");
    mac_txd <= 4'h1;
    mac_tx_en <= 1'b1;
    wait_col(1'b1, 400);
    rd(STATUS_OFFSET);
    check(rd_data[STAT_JABBER_BIT] === 1'b1 && crs === 1'b0, "jabber status");
    count_toggles(1);
    cnt = 0;
    repeat (200) begin
      @(posedge clock);
      if (line_tx_en === 1'b1)
        cnt++;
    end
    check(cnt > 0 && cnt <= 20, "only link pulses");
    rx_activity <= 1'b1;
    tick(10);
    check(col === 1'b1 && crs === 1'b1, "jabber with receive");
    rx_activity <= 1'b0;
    mac_tx_en <= 1'b0;
    tick(300);
    check(col === 1'b1, "unjab wait");
    wait_col(1'b0, 400);
    wr(CTRL_OFFSET, 32'h1002);
    mac_tx_en <= 1'b1;
    tick(400);
    check(col === 1'b0 && line_tx_en === 1'b1, "jabber disabled");
    mac_tx_en <= 1'b0;
    wr(CTRL_OFFSET, 32'h0);
    $display("jabber done");
    reversed <= 1'b1;
    pulse_req <= 1'b1;
    signal_detect <= 1'b1;
    tick(20);
    pulse_req <= 1'b0;
    rd(STATUS_OFFSET);
    check(rd_data[STAT_POL_INV_BIT] === 1'b1 && rd_data[STAT_POL_LOCK_BIT] === 1'b0, "polarity");
    repeat (2) begin
      rx_activity <= 1'b1;
      run <= 1'b1;
      tick(200);
      rx_activity <= 1'b0;
      run <= 1'b0;
      tick(60);
    end
    reversed <= 1'b0;
    pulse_req <= 1'b1;
    tick(20);
    pulse_req <= 1'b0;
    rd(STATUS_OFFSET);
    check(rd_data[STAT_POL_LOCK_BIT] === 1'b1 && rd_data[STAT_POL_INV_BIT] === 1'b1, "lock");
    check(nib_seen > 0, "nibbles");
    aneg_link_good <= 1'b0;
    tick(20);
    rd(STATUS_OFFSET);
    check(rd_data[STAT_POL_LOCK_BIT] === 1'b0 && rd_data[STAT_LINK_PASS_BIT] === 1'b0, "unlock");
    aneg_link_good <= 1'b1;
    $display("polarity done");
    wr(CTRL_OFFSET, 32'h1);
    tick(4);
    check(synth_100_set === 1'b1, "synth 100");
    run <= 1'b1;
    tick(300);
    sym_exp <= 5'h1f;
    sym_on <= 1'b1;
    count_toggles(400);
    check(cnt >= 9 && cnt <= 11, "line receive clock");
    sym_on <= 1'b0;
    nrz <= 1'b0;
    tick(200);
    sym_exp <= 5'h00;
    sym_on <= 1'b1;
    tick(600);
    rd(STATUS_OFFSET);
    check(rd_data[STAT_RX_LOCK_BIT] === 1'b1, "lock through run");
    sym_on <= 1'b0;
    run <= 1'b0;
    signal_detect <= 1'b0;
    // detect loss passes the synchroniser before the clock source swaps
    tick(5);
    count_toggles(40);
    check(cnt >= 19 && cnt <= 21, "fallback clock");
    clk_en <= 1'b0;
    tick(1);
    count_toggles(20);
    check(cnt == 0, "clock enable freeze");
    clk_en <= 1'b1;
    $display("receive done");
    conclude();
  end
endmodule : tenbase_t_pcs_link_control_bench
